// ===== rfs_regs.svh
// Constants for the regulator fault supervisor
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH

`define RFS_CORE_GAIN      21'h0_0005
`define RFS_CORE_DIV       21'h0_0006
`define RFS_NB_SRC_UA      17'h0_000A
`define RFS_VCC_UVLO_MV    13'h0F3C
`define RFS_OV_SEVERE_MV   13'h0708
`define RFS_OV_RELEASE_MV  13'h0352
`define RFS_UV_MARGIN_MV   14'h0127
`define RFS_OV_MARGIN_MV   14'h00C8
`define RFS_CLK_PERIOD_NS  32'h0000_0028
`define RFS_UV_TIME_NS     32'h000F_4240
`define RFS_SS_TIME_NS     32'h0007_A120
`define RFS_UV_CYCLES      ((`RFS_UV_TIME_NS + `RFS_CLK_PERIOD_NS - 32'h0000_0001) / `RFS_CLK_PERIOD_NS)
`define RFS_SS_CYCLES      ((`RFS_SS_TIME_NS + `RFS_CLK_PERIOD_NS - 32'h0000_0001) / `RFS_CLK_PERIOD_NS)

`endif

// ===== rfs_pkg.sv
// Types for the regulator fault supervisor
package rfs_pkg;

	typedef enum logic [1:0] {
		RFS_OFF   = 2'h0,
		RFS_SOFT  = 2'h1,
		RFS_RUN   = 2'h3,
		RFS_LATCH = 2'h2
	} rfs_state_t;

	typedef struct packed {
		logic hi_on;
		logic lo_on;
		logic hi_z;
	} rfs_gate_t;

	typedef struct packed {
		logic hi_req;
		logic lo_req;
	} rfs_pwm_t;

	typedef struct packed {
		logic oc;
		logic ov;
		logic uv;
	} rfs_fault_t;

	typedef struct packed {
		logic        enable;
		logic [12:0] vcc_mv;
		logic [15:0] core_cap_uv;
		logic [15:0] core_trip_uv;
		logic [15:0] nb_drop_uv;
		logic [11:0] nb_trip_ohm;
		logic [12:0] core_vout_mv;
		logic [12:0] nb_vout_mv;
	} rfs_pins_t;

endpackage

// ===== rfs_uv_timer.sv
// Undervoltage qualification timer for one output
`timescale 1ns/1ps
`default_nettype none
module rfs_uv_timer #(
	parameter int CYCLES = 25000,
	parameter int CNT_W  = 16
) (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic arm,
	input  wire logic below,
	output var  logic fire
);
	logic [CNT_W-1:0] cnt_reg;

	always_ff @(posedge clk) begin
		if (srst || !arm || !below) begin
			cnt_reg <= '0;
			fire    <= 1'b0;
		end else begin
			if (cnt_reg != CNT_W'(CYCLES - 1)) begin
				cnt_reg <= cnt_reg + CNT_W'(1);
			end
			fire <= (cnt_reg == CNT_W'(CYCLES - 1));
		end
	end

	a_uv_restart_zero: assert property (@(posedge clk) disable iff (srst)
		(!below) |=> (cnt_reg == '0 && !fire))
		else $error("uv timer not restarted");

	a_uv_fire_count: assert property (@(posedge clk) disable iff (srst)
		$rose(fire) |-> ($past(cnt_reg) == CNT_W'(CYCLES - 1) && $past(below) && $past(arm)))
		else $error("uv fired early");
endmodule // rfs_uv_timer
`default_nettype wire

// ===== rfs_ov_clamp.sv
// Severe overvoltage low-side clamp for one output
`timescale 1ns/1ps
`include "rfs_regs.svh"
`default_nettype none
module rfs_ov_clamp (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic        enable,
	input  wire logic [12:0] vout_mv,
	output var  logic        clamp
);
	always_ff @(posedge clk) begin
		if (srst || !enable) begin
			clamp <= 1'b0;
		end else if (vout_mv > `RFS_OV_SEVERE_MV) begin
			clamp <= 1'b1;
		end else if (vout_mv < `RFS_OV_RELEASE_MV) begin
			clamp <= 1'b0;
		end
	end

	a_clamp_set: assert property (@(posedge clk) disable iff (srst)
		(enable && vout_mv > `RFS_OV_SEVERE_MV) |=> clamp)
		else $error("severe ov clamp missed");

	a_clamp_release: assert property (@(posedge clk) disable iff (srst)
		(clamp && enable && vout_mv >= `RFS_OV_RELEASE_MV) |=> clamp)
		else $error("clamp released above release level");
endmodule // rfs_ov_clamp
`default_nettype wire

// ===== rfs_supervisor.sv
// Fault supervisor top for core and northbridge outputs
`timescale 1ns/1ps
`include "rfs_regs.svh"
`default_nettype none
module rfs_supervisor #(
	parameter int UV_CYCLES = `RFS_UV_CYCLES,
	parameter int SS_CYCLES = `RFS_SS_CYCLES,
	parameter int CNT_W     = 16
) (
	input  wire logic                   clk,
	input  wire logic                   srst,
	input  wire logic                   enable_pin,
	input  wire logic [12:0]            vcc_mv,
	input  wire logic [15:0]            core_sense_cap_uv,
	input  wire logic [15:0]            core_trip_level_pin,
	input  wire logic [15:0]            nb_switch_drop_uv,
	input  wire logic [11:0]            nb_trip_resistor_pin,
	input  wire logic [12:0]            core_vout_mv,
	input  wire logic [12:0]            nb_vout_mv,
	input  wire logic [1:0][12:0]       voltage_setpoint_code,
	input  wire rfs_pkg::rfs_pwm_t [1:0] pwm_req,
	output var  rfs_pkg::rfs_gate_t [1:0] gate_drive,
	output var  logic                   power_good_output_o,
	output var  logic                   power_good_output_oe,
	output var  logic                   soft_start_active,
	output var  rfs_pkg::rfs_fault_t    fault_status,
	output var  rfs_pkg::rfs_state_t    sup_state
);
	import rfs_pkg::*;

	rfs_pins_t        pins_raw;
	rfs_pins_t        meta_reg;
	rfs_pins_t        sync_reg;
	logic [1:0][12:0] vout_mv;
	logic             en_ok;
	logic             core_oc;
	logic             nb_oc;
	logic [1:0]       under;
	logic [1:0]       over;
	logic [1:0]       clamp;
	logic [1:0]       uv_fire;
	logic             in_limits;
	logic             fault_any;
	logic             active;
	logic [CNT_W-1:0] ss_cnt_reg;
	logic             ss_done;

	// Core trip compare, only the cap side scaled (gain times divider) to avoid the divide
	function automatic logic f_core_oc(input logic [15:0] cap_uv, input logic [15:0] trip_uv);
		f_core_oc = (21'(cap_uv) * `RFS_CORE_GAIN * `RFS_CORE_DIV) > 21'(trip_uv);
	endfunction

	// Northbridge trip compare against source drop on the resistor
	function automatic logic f_nb_oc(input logic [15:0] drop_uv, input logic [11:0] r_ohm);
		f_nb_oc = 17'(drop_uv) > (17'(r_ohm) * `RFS_NB_SRC_UA);
	endfunction

	// Output at least the margin below its setpoint
	function automatic logic f_under(input logic [12:0] v, input logic [12:0] set);
		f_under = (14'(v) + `RFS_UV_MARGIN_MV) <= 14'(set);
	endfunction

	// Output above setpoint plus margin
	function automatic logic f_over(input logic [12:0] v, input logic [12:0] set);
		f_over = 14'(v) > (14'(set) + `RFS_OV_MARGIN_MV);
	endfunction

	// Pin inputs pass two flip-flops
	assign pins_raw = '{
		enable:       enable_pin,
		vcc_mv:       vcc_mv,
		core_cap_uv:  core_sense_cap_uv,
		core_trip_uv: core_trip_level_pin,
		nb_drop_uv:   nb_switch_drop_uv,
		nb_trip_ohm:  nb_trip_resistor_pin,
		core_vout_mv: core_vout_mv,
		nb_vout_mv:   nb_vout_mv
	};

	always_ff @(posedge clk) begin
		if (srst) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= pins_raw;
			sync_reg <= meta_reg;
		end
	end

	// Detectors
	assign vout_mv[0] = sync_reg.core_vout_mv;
	assign vout_mv[1] = sync_reg.nb_vout_mv;
	assign en_ok      = sync_reg.enable && (sync_reg.vcc_mv >= `RFS_VCC_UVLO_MV);
	assign core_oc    = f_core_oc(sync_reg.core_cap_uv, sync_reg.core_trip_uv);
	assign nb_oc      = f_nb_oc(sync_reg.nb_drop_uv, sync_reg.nb_trip_ohm);
	assign active     = (sup_state == RFS_SOFT) || (sup_state == RFS_RUN);
	assign fault_any  = fault_status.oc || fault_status.ov || fault_status.uv;
	assign in_limits  = !(|under) && !(|over);
	assign ss_done    = (ss_cnt_reg == CNT_W'(SS_CYCLES - 1));

	always_comb begin
		for (int i = 0; i < 2; i++) begin
			under[i] = f_under(vout_mv[i], voltage_setpoint_code[i]);
			over[i]  = f_over(vout_mv[i], voltage_setpoint_code[i]);
		end
	end

	// Per-output clamp and undervoltage timer
	for (genvar gi = 0; gi < 2; gi++) begin : g_chan
		rfs_ov_clamp u_clamp (
			.clk     (clk),
			.srst    (srst),
			.enable  (en_ok),
			.vout_mv (vout_mv[gi]),
			.clamp   (clamp[gi])
		);

		rfs_uv_timer #(
			.CYCLES (UV_CYCLES),
			.CNT_W  (CNT_W)
		) u_uv (
			.clk   (clk),
			.srst  (srst),
			.arm   (sup_state == RFS_RUN && en_ok),
			.below (under[gi]),
			.fire  (uv_fire[gi])
		);
	end

	// Latched faults, cleared only by enable or supply loss
	always_ff @(posedge clk) begin
		if (srst || !en_ok) begin
			fault_status <= '0;
		end else begin
			if (active && (core_oc || nb_oc)) begin
				fault_status.oc <= 1'b1;
			end
			if ((|over) || (|clamp)) begin
				fault_status.ov <= 1'b1;
			end
			if (sup_state == RFS_RUN && (|uv_fire)) begin
				fault_status.uv <= 1'b1;
			end
		end
	end

	// Sequencer
	always_ff @(posedge clk) begin
		if (srst || !en_ok) begin
			sup_state <= RFS_OFF;
		end else begin
			case (sup_state)
				RFS_OFF: begin
					sup_state <= RFS_SOFT;
				end
				RFS_SOFT: begin
					if (fault_any) begin
						sup_state <= RFS_LATCH;
					end else if (ss_done && in_limits) begin
						sup_state <= RFS_RUN;
					end
				end
				RFS_RUN: begin
					if (fault_any) begin
						sup_state <= RFS_LATCH;
					end
				end
				RFS_LATCH: begin
					sup_state <= RFS_LATCH;
				end
				default: begin
					sup_state <= RFS_OFF;
				end
			endcase
		end
	end

	// Soft-start timer
	always_ff @(posedge clk) begin
		if (srst || sup_state != RFS_SOFT) begin
			ss_cnt_reg <= '0;
		end else if (!ss_done) begin
			ss_cnt_reg <= ss_cnt_reg + CNT_W'(1);
		end
	end

	// Gate drivers
	always_ff @(posedge clk) begin
		for (int i = 0; i < 2; i++) begin
			if (srst) begin
				gate_drive[i] <= '{hi_on: 1'b0, lo_on: 1'b0, hi_z: 1'b1};
			end else if (clamp[i]) begin
				gate_drive[i] <= '{hi_on: 1'b0, lo_on: 1'b1, hi_z: 1'b0};
			end else if (fault_status.oc) begin
				gate_drive[i] <= '{hi_on: 1'b0, lo_on: 1'b0, hi_z: 1'b1};
			end else if (fault_status.ov || fault_status.uv) begin
				gate_drive[i] <= '{hi_on: 1'b0, lo_on: 1'b0, hi_z: 1'b0};
			end else if (active && en_ok) begin
				gate_drive[i] <= '{hi_on: pwm_req[i].hi_req,
					lo_on: pwm_req[i].lo_req && !pwm_req[i].hi_req, hi_z: 1'b0};
			end else begin
				gate_drive[i] <= '{hi_on: 1'b0, lo_on: 1'b0, hi_z: 1'b1};
			end
		end
	end

	// Power-good, open drain: enable high pulls the pin low
	always_ff @(posedge clk) begin
		if (srst) begin
			power_good_output_o  <= 1'b0;
			power_good_output_oe <= 1'b1;
			soft_start_active    <= 1'b0;
		end else begin
			power_good_output_o  <= (sup_state == RFS_RUN) && en_ok && !fault_any && in_limits;
			power_good_output_oe <= !((sup_state == RFS_RUN) && en_ok && !fault_any && in_limits);
			soft_start_active    <= (sup_state == RFS_SOFT);
		end
	end

	a_core_oc_trip: assert property (@(posedge clk) disable iff (srst)
		(active && en_ok && core_oc) |=> fault_status.oc)
		else $error("core overcurrent not latched");

	a_nb_oc_trip: assert property (@(posedge clk) disable iff (srst)
		(active && en_ok && nb_oc) |=> fault_status.oc)
		else $error("northbridge overcurrent not latched");

	a_oc_tristate: assert property (@(posedge clk) disable iff (srst)
		(fault_status.oc && !(|clamp)) |=> (gate_drive[0].hi_z && gate_drive[1].hi_z))
		else $error("drivers not tri-stated on overcurrent");

	a_pg_low_fault: assert property (@(posedge clk) disable iff (srst)
		fault_any |=> (!power_good_output_o && power_good_output_oe))
		else $error("power-good released during fault");

	a_no_restart: assert property (@(posedge clk) disable iff (srst)
		(sup_state == RFS_LATCH && en_ok) |=> (sup_state == RFS_LATCH))
		else $error("restart without enable toggle");

	a_fault_hold: assert property (@(posedge clk) disable iff (srst)
		(fault_status.ov && en_ok) |=> fault_status.ov)
		else $error("overvoltage latch cleared while enabled");

	a_soft_start: assert property (@(posedge clk) disable iff (srst)
		(sup_state == RFS_OFF && en_ok) |=> (sup_state == RFS_SOFT))
		else $error("soft-start not entered");

	a_ov_always: assert property (@(posedge clk) disable iff (srst)
		(en_ok && (|over)) |=> fault_status.ov)
		else $error("overvoltage missed");

	a_drivers_off: assert property (@(posedge clk) disable iff (srst)
		((fault_status.ov || fault_status.uv) && !fault_status.oc && !(|clamp))
		|=> (!gate_drive[0].hi_on && !gate_drive[0].lo_on && !gate_drive[1].hi_on && !gate_drive[1].lo_on))
		else $error("switches on during latched fault");

	a_uv_latch: assert property (@(posedge clk) disable iff (srst)
		(sup_state == RFS_RUN && en_ok && (|uv_fire)) |=> fault_status.uv)
		else $error("undervoltage not latched");

	a_pg_after_run: assert property (@(posedge clk) disable iff (srst)
		$rose(power_good_output_o) |-> ($past(sup_state) == RFS_RUN))
		else $error("power-good released outside run");

	a_pg_soft_low: assert property (@(posedge clk) disable iff (srst)
		(sup_state == RFS_SOFT || sup_state == RFS_OFF) |=> power_good_output_oe)
		else $error("power-good released before run");

	a_oc_shutdown: assert property (@(posedge clk) disable iff (srst)
		(fault_status.oc && en_ok) |=> (sup_state == RFS_LATCH))
		else $error("regulators not shut down on overcurrent");

	a_uv_ungated: assert property (@(posedge clk) disable iff (srst)
		(sup_state == RFS_RUN && en_ok && (|uv_fire) && fault_status.oc) |=> fault_status.uv)
		else $error("undervoltage masked by overcurrent");

	a_clamp_core: assert property (@(posedge clk) disable iff (srst)
		clamp[0] |=> (gate_drive[0].lo_on && !gate_drive[0].hi_on && !gate_drive[0].hi_z))
		else $error("core low side not clamped");

	a_clamp_nb: assert property (@(posedge clk) disable iff (srst)
		clamp[1] |=> (gate_drive[1].lo_on && !gate_drive[1].hi_on && !gate_drive[1].hi_z))
		else $error("northbridge low side not clamped");

endmodule // rfs_supervisor
`default_nettype wire

// ===== rfs_sys_monitor.sv
// System monitor model reading power-good and driving enable
`timescale 1ns/1ps
`default_nettype none
module rfs_sys_monitor (
	input  wire logic clk,
	input  wire logic want_on,
	input  wire logic pg_oe,
	output var  logic enable_pin,
	output wire logic pg_pin
);
	// Open-drain pin with pull-up
	assign pg_pin = pg_oe ? 1'b0 : 1'b1;
	initial enable_pin = 1'b0;
	// Enable toggle or supply loss is the way out of a latched fault
	always @(posedge clk) begin
		enable_pin <= want_on;
	end
endmodule // rfs_sys_monitor
`default_nettype wire

// ===== rfs_supervisor_tb.sv
// Self-checking testbench for the regulator fault supervisor
`timescale 1ns/1ps
`default_nettype none
module rfs_supervisor_tb;
	import rfs_pkg::*;
	logic             clk = 1'b0, srst = 1'b1, want_on = 1'b0, enable_pin, pg_pin, oc;
	logic [12:0]      vcc = 13'h1388, cvo = 13'h03E8, nvo = 13'h03E8;
	logic [15:0]      cap = 16'h0000, trip = 16'hFFFF, drop = 16'h0000, lf = 16'h003E;
	logic [11:0]      rnb = 12'h0FFF;
	logic [1:0][12:0] sp = {13'h03E8, 13'h03E8};
	rfs_pwm_t [1:0]   pwm = '0;
	rfs_gate_t [1:0]  gate;
	logic             pg_o, pg_oe, ss_act;
	rfs_fault_t       flt;
	rfs_state_t       st;
	int               fails = 0, compares = 0;

	rfs_supervisor #(.UV_CYCLES(20), .SS_CYCLES(10), .CNT_W(16)) rfs_supervisor_i (
		.clk(clk), .srst(srst), .enable_pin(enable_pin), .vcc_mv(vcc),
		.core_sense_cap_uv(cap), .core_trip_level_pin(trip), .nb_switch_drop_uv(drop),
		.nb_trip_resistor_pin(rnb), .core_vout_mv(cvo), .nb_vout_mv(nvo),
		.voltage_setpoint_code(sp), .pwm_req(pwm), .gate_drive(gate),
		.power_good_output_o(pg_o), .power_good_output_oe(pg_oe),
		.soft_start_active(ss_act), .fault_status(flt), .sup_state(st));
	rfs_sys_monitor rfs_sys_monitor_i (.clk(clk), .want_on(want_on), .pg_oe(pg_oe),
		.enable_pin(enable_pin), .pg_pin(pg_pin));

	always #20 clk = ~clk;

	function automatic logic [15:0] nx(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk_vec(input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk_bit(input logic g, input logic e);
		chk_vec({31'h0, g}, {31'h0, e});
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask

	task automatic up;
		want_on = 1'b1;
		for (int i = 0; i < 200 && st !== RFS_SOFT; i++) cyc(1);
		cyc(1);
		chk_bit(ss_act, 1'b1);
		chk_bit(pg_oe, 1'b1);
		for (int i = 0; i < 200 && st !== RFS_RUN; i++) cyc(1);
		cyc(2);
		chk_vec(32'(st), 32'(RFS_RUN));
		chk_bit(pg_o, 1'b1);
		chk_bit(pg_pin, 1'b1);
		chk_bit(ss_act, 1'b0);
	endtask

	task automatic down;
		want_on = 1'b0;
		cyc(6);
		chk_vec(32'(flt), 32'h0000_0000);
		chk_vec(32'(st), 32'(RFS_OFF));
		chk_bit(pg_oe, 1'b1);
	endtask

	initial begin
		#(40 * 4000);
		fails++;
		tally_and_finish();
	end

	initial begin
		cyc(2);
		srst = 1'b0;
		chk_vec(32'(gate), 32'h0000_0009);
		chk_bit(pg_oe, 1'b1);
		up();
		$display("test startup done");
		for (int i = 0; i < 8; i++) begin
			lf = nx(lf);
			cap = {4'h0, lf[11:0]};
			lf = nx(lf);
			trip = lf;
			lf = nx(lf);
			drop = {4'h0, lf[11:0]};
			lf = nx(lf);
			rnb = {2'h0, lf[9:0]};
			pwm = lf[3:0];
			if (i < 2) begin
				cap = 16'h0064;
				trip = 16'h0BB8 - 16'(i);
				drop = 16'h0000;
			end
			oc = (int'(cap) * 30 > int'(trip)) || (int'(drop) > 10 * int'(rnb));
			cyc(4);
			chk_bit(flt.oc, oc);
			if (oc) begin
				chk_vec(32'(gate), 32'h0000_0009);
				chk_bit(pg_pin, 1'b0);
				cyc(20);
				chk_vec(32'(st), 32'(RFS_LATCH));
			end else begin
				chk_vec(32'(gate), {26'h0, lf[3], lf[2] & ~lf[3], 1'b0, lf[1], lf[0] & ~lf[1], 1'b0});
			end
			cap = 16'h0000;
			trip = 16'hFFFF;
			drop = 16'h0000;
			down();
			up();
		end
		$display("test overcurrent done");
		trip = 16'h0000;
		cap = 16'h0FFF;
		cyc(4);
		nvo = 13'h0709;
		cyc(4);
		chk_vec(32'(gate), 32'h0000_0011);
		nvo = 13'h03E8;
		cap = 16'h0000;
		trip = 16'hFFFF;
		down();
		up();
		$display("test ov after oc done");
		nvo = 13'h04B1;
		cyc(4);
		chk_bit(flt.ov, 1'b1);
		chk_vec(32'(gate), 32'h0000_0000);
		nvo = 13'h03E8;
		vcc = 13'h0F3C;
		cyc(6);
		chk_bit(flt.ov, 1'b1);
		chk_bit(pg_pin, 1'b0);
		vcc = 13'h0F3B;
		cyc(6);
		chk_vec(32'(flt), 32'h0000_0000);
		chk_vec(32'(st), 32'(RFS_OFF));
		vcc = 13'h1388;
		up();
		$display("test supply reset done");
		cvo = 13'h0709;
		cyc(4);
		chk_vec(32'(gate), 32'h0000_0002);
		chk_bit(flt.ov, 1'b1);
		chk_bit(pg_pin, 1'b0);
		cvo = 13'h0320;
		cyc(4);
		chk_vec(32'(gate), 32'h0000_0000);
		cvo = 13'h0709;
		cyc(4);
		chk_vec(32'(gate), 32'h0000_0002);
		cvo = 13'h03E8;
		cyc(8);
		chk_vec(32'(st), 32'(RFS_LATCH));
		down();
		up();
		$display("test severe ov done");
		cvo = 13'h02C1;
		cyc(15);
		cvo = 13'h03E8;
		cyc(1);
		cvo = 13'h02C1;
		cyc(15);
		chk_bit(flt.uv, 1'b0);
		cyc(12);
		chk_bit(flt.uv, 1'b1);
		chk_bit(flt.oc, 1'b0);
		chk_vec(32'(gate), 32'h0000_0000);
		chk_bit(pg_pin, 1'b0);
		cvo = 13'h03E8;
		down();
		$display("test undervoltage done");
		tally_and_finish();
	end
endmodule // rfs_supervisor_tb
`default_nettype wire
